// ===== ddsc_pkg.sv
// shared constants of the dual dac serial control link
package ddsc_pkg;
	localparam int          WORD_BITS     = 24;
	localparam int          DATA_BITS     = 16;
	localparam int          RW_POS        = 23;
	localparam int          REG_LSB       = 19;
	localparam int          ADDR_LSB      = 16;
	localparam logic [4:0]  BIT_LAST      = 5'h17;
	localparam logic [2:0]  REG_DAC       = 3'h0;
	localparam logic [2:0]  REG_RANGE     = 3'h1;
	localparam logic [2:0]  REG_POWER     = 3'h2;
	localparam logic [2:0]  REG_CTRL      = 3'h3;
	localparam logic [2:0]  ADDR_A        = 3'h0;
	localparam logic [2:0]  ADDR_B        = 3'h2;
	localparam logic [2:0]  ADDR_ALL      = 3'h4;
	localparam logic [2:0]  CMD_NOP       = 3'h0;
	localparam logic [2:0]  CMD_SETUP     = 3'h1;
	localparam logic [2:0]  CMD_CLEAR     = 3'h4;
	localparam logic [2:0]  CMD_LOAD      = 3'h5;
	localparam int          CTRL_SDO_DIS  = 0;
	localparam int          CTRL_CLR_SEL  = 2;
	localparam int          POWER_A_BIT   = 0;
	localparam int          POWER_B_BIT   = 2;
	localparam logic [2:0]  RANGE_BIP_LOW = 3'h3;
	localparam logic [15:0] CODE_ZERO     = 16'h0000;
	localparam logic [15:0] CODE_MID      = 16'h8000;
	localparam logic [15:0] RESET_CODE    = 16'h0000;
	// synchronised pin positions in the device
	localparam int          P_SCLK        = 0;
	localparam int          P_FS          = 1;
	localparam int          P_SERIAL_DATA_IN        = 2;
	localparam int          P_LOAD_OUTPUTS_N        = 3;
	localparam int          P_CLR         = 4;
	localparam int          P_CODE        = 5;
	localparam int          PIN_COUNT     = 6;
	// host timing and register map
	localparam int          SYS_CLK_NS    = 10;
	localparam int          HALF_SCLK_NS  = 80;
	localparam int          HALF_CYC      = HALF_SCLK_NS / SYS_CLK_NS;
	localparam int          SAMPLE_CYC    = HALF_CYC / 2;
	localparam logic [7:0]  H_TX          = 8'h00;
	localparam logic [7:0]  H_CTRL        = 8'h04;
	localparam logic [7:0]  H_STATUS      = 8'h08;
	localparam logic [7:0]  H_RX          = 8'h0C;
	localparam int          HC_GO         = 0;
	localparam int          HC_LOAD_OUTPUTS_N       = 1;
	localparam int          HC_CLR        = 2;
endpackage

// ===== ddsc_link_if.sv
// serial link between host controller and dac control logic
`timescale 1ns/10ps
interface ddsc_link_if;
	logic sclk;
	logic syncN;
	logic serial_data_in;
	logic ldacN;
	logic clrN;
	logic sdoOut;
	logic sdoOe;
	logic sdoLine;
	// undriven readout line is pulled high
	assign sdoLine = sdoOe ? sdoOut : 1'b1;
	modport dev (input sclk, syncN, serial_data_in, ldacN, clrN, output sdoOut, sdoOe);
	modport host (output sclk, syncN, serial_data_in, ldacN, clrN, input sdoLine);
endinterface

// ===== ddsc_device.sv
// dual dac serial control logic: shift register, decode, load and clear
// Contract
// - 24-bit shift register, msb first, framed
// - word is rw, reserved, reg, addr, data
// - frame starts on falling frame select
// - wrong edge count discards the frame
// - frame select rise writes addressed register
// - host sends exact clock burst count
// - overflow bits leave on readout, rising edge
// - daisy chain uses 24 times n clocks
// - read command returns register next frame
// - readout enabled during read despite disable
// - 0x800000 then 0x180000 reads channel a
// - load low while shifting updates at latch
// - load falling edge updates all outputs
// - clear pin forces zero or midscale
// - no updates while clear pin low
// - clear command clears like the pin
// - reset zeroes all registers, channels off
// - code writes to powered-down channel are ignored
// - host sets range, powers up, then codes
// - bipolar twos complement converts to offset
`timescale 1ns/10ps
module ddsc_device
	import ddsc_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	ddsc_link_if.dev               link,
	input  wire logic              codingSel,
	output logic [DATA_BITS-1:0]   dacCodeA,
	output logic [DATA_BITS-1:0]   dacCodeB,
	output logic [1:0]             channelOn
);
	typedef struct packed {
		logic [PIN_COUNT-1:0]           s1;
		logic [PIN_COUNT-1:0]           s2;
		logic [PIN_COUNT-1:0]           s3;
		logic [PIN_COUNT-1:0]           pin;
		logic                           active;
		logic [4:0]                     bitCnt;
		logic                           full;
		logic [WORD_BITS-1:0]           shift;
		logic                           serial_data_out;
		logic                           readPend;
		logic                           readOn;
		logic [2:0]                     readReg;
		logic [2:0]                     readAddr;
		logic [1:0][DATA_BITS-1:0]      inReg;
		logic [1:0][DATA_BITS-1:0]      outReg;
		logic [1:0][2:0]                range;
		logic [1:0]                     power;
		logic                           clrSel;
		logic                           sdoDis;
	} ddsc_dev_s;

	ddsc_dev_s q;
	ddsc_dev_s next_q;

	function automatic logic chanHit(input logic [2:0] a, input int ch);
		chanHit = (a == ADDR_ALL) || (a == (ch == 0 ? ADDR_A : ADDR_B));
	endfunction

	// output registers always hold offset or straight binary
	function automatic logic [DATA_BITS-1:0] normCode(
		input logic [DATA_BITS-1:0] d,
		input logic [2:0]           rng,
		input logic                 twos
	);
		normCode = d;
		if (rng >= RANGE_BIP_LOW && twos) begin
			normCode = {~d[DATA_BITS-1], d[DATA_BITS-2:0]};
		end
	endfunction

	function automatic logic [DATA_BITS-1:0] readValue(
		input ddsc_dev_s  s,
		input logic [2:0] r,
		input logic [2:0] a
	);
		int ch;
		ch = (a == ADDR_B) ? 1 : 0;
		readValue = '0;
		unique case (r)
			REG_DAC: readValue = s.inReg[ch];
			REG_RANGE: readValue = {13'h0000, s.range[ch]};
			REG_POWER: begin
				readValue[POWER_A_BIT] = s.power[0];
				readValue[POWER_B_BIT] = s.power[1];
			end
			REG_CTRL: begin
				readValue[CTRL_SDO_DIS] = s.sdoDis;
				readValue[CTRL_CLR_SEL] = s.clrSel;
			end
			default: readValue = '0;
		endcase
	endfunction

	always_comb begin
		logic                   sclkFall;
		logic                   sclkRise;
		logic                   fsFall;
		logic                   fsRise;
		logic                   ldacFall;
		logic                   clrLow;
		logic                   doLoad;
		logic                   doClear;
		logic [WORD_BITS-1:0]   w;
		logic [2:0]             wReg;
		logic [2:0]             wAddr;
		logic [DATA_BITS-1:0]   wData;
		next_q = q;
		next_q.s1 = {codingSel, link.clrN, link.ldacN, link.serial_data_in, link.syncN,
			link.sclk};
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		// a pin change counts once stages two and three agree
		next_q.pin = (q.s2 & q.s3) | (q.pin & (q.s2 ^ q.s3));
		sclkFall = q.pin[P_SCLK] & ~next_q.pin[P_SCLK];
		sclkRise = ~q.pin[P_SCLK] & next_q.pin[P_SCLK];
		fsFall = q.pin[P_FS] & ~next_q.pin[P_FS];
		fsRise = ~q.pin[P_FS] & next_q.pin[P_FS];
		ldacFall = q.pin[P_LOAD_OUTPUTS_N] & ~next_q.pin[P_LOAD_OUTPUTS_N] & next_q.pin[P_FS];
		clrLow = ~next_q.pin[P_CLR];
		doLoad = ldacFall;
		doClear = clrLow;
		w = q.shift;
		wReg = w[REG_LSB +: 3];
		wAddr = w[ADDR_LSB +: 3];
		wData = w[DATA_BITS-1:0];

		if (fsFall) begin
			next_q.active = 1'b1;
			next_q.bitCnt = '0;
			next_q.full = 1'b0;
			next_q.readOn = q.readPend;
			next_q.readPend = 1'b0;
			if (q.readPend) begin
				next_q.shift = {8'h00, readValue(q, q.readReg, q.readAddr)};
				next_q.serial_data_out = 1'b0;
			end else begin
				next_q.serial_data_out = q.shift[WORD_BITS-1];
			end
		end else if (fsRise && q.active) begin
			next_q.active = 1'b0;
			next_q.readOn = 1'b0;
			// whole multiples of 24 edges keep daisy chains working
			if (q.full && q.bitCnt == 5'h00) begin
				if (w[RW_POS]) begin
					next_q.readPend = 1'b1;
					next_q.readReg = wReg;
					next_q.readAddr = wAddr;
				end else begin
					unique case (wReg)
						REG_DAC: begin
							for (int ch = 0; ch < 2; ch++) begin
								if (chanHit(wAddr, ch) && q.power[ch]) begin
									next_q.inReg[ch] = wData;
									if (~next_q.pin[P_LOAD_OUTPUTS_N] && !clrLow) begin
										next_q.outReg[ch] = normCode(wData,
											q.range[ch], next_q.pin[P_CODE]);
									end
								end
							end
						end
						REG_RANGE: begin
							for (int ch = 0; ch < 2; ch++) begin
								if (chanHit(wAddr, ch)) begin
									next_q.range[ch] = wData[2:0];
								end
							end
						end
						REG_POWER: begin
							next_q.power[0] = wData[POWER_A_BIT];
							next_q.power[1] = wData[POWER_B_BIT];
						end
						REG_CTRL: begin
							unique case (wAddr)
								CMD_SETUP: begin
									next_q.sdoDis = wData[CTRL_SDO_DIS];
									next_q.clrSel = wData[CTRL_CLR_SEL];
								end
								CMD_CLEAR: doClear = 1'b1;
								CMD_LOAD: doLoad = 1'b1;
								default: ; // no_op and unused commands
							endcase
						end
						default: ;
					endcase
				end
			end
		end else if (q.active && sclkFall) begin
			next_q.shift = {q.shift[WORD_BITS-2:0], next_q.pin[P_SERIAL_DATA_IN]};
			next_q.bitCnt = (q.bitCnt == BIT_LAST) ? 5'h00 : q.bitCnt + 5'h01;
			if (q.bitCnt == BIT_LAST) begin
				next_q.full = 1'b1;
			end
		end else if (q.active && sclkRise) begin
			// overflow bit changes on rising edge, valid at the falling one
			next_q.serial_data_out = q.shift[WORD_BITS-1];
		end

		if (doLoad && !clrLow) begin
			for (int ch = 0; ch < 2; ch++) begin
				next_q.outReg[ch] = normCode(next_q.inReg[ch], next_q.range[ch],
					next_q.pin[P_CODE]);
			end
		end
		// clear is applied last so that it beats any same-cycle load
		if (doClear) begin
			for (int ch = 0; ch < 2; ch++) begin
				next_q.outReg[ch] = next_q.clrSel ? CODE_MID : CODE_ZERO;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.s1 <= '1;
			q.s2 <= '1;
			q.s3 <= '1;
			q.pin <= '1;
			q.inReg <= {RESET_CODE, RESET_CODE};
			q.outReg <= {RESET_CODE, RESET_CODE};
		end else begin
			q <= next_q;
		end
	end

	assign link.sdoOut = q.serial_data_out;
	assign link.sdoOe = ~q.sdoDis | q.readOn;
	assign dacCodeA = q.outReg[0];
	assign dacCodeB = q.outReg[1];
	assign channelOn = q.power;
endmodule

// ===== ddsc_host.sv
// host controller end: frames command words onto the serial link
`timescale 1ns/10ps
module ddsc_host
	import ddsc_pkg::*;
#(
	parameter int CHAIN_N = 1
)
(
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	ddsc_link_if.host              link,
	input  wire logic [7:0]        addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic [31:0]            rdata
);
	localparam int           FRAME_BITS = WORD_BITS * CHAIN_N;
	localparam logic [7:0]   HALF_LAST  = 8'(HALF_CYC - 1);
	localparam logic [7:0]   SAMPLE_AT  = 8'(SAMPLE_CYC);
	localparam logic [15:0]  FRAME_LEN  = 16'(FRAME_BITS);

	typedef enum logic [2:0] {
		H_IDLE  = 3'h0,
		H_LEAD  = 3'h1,
		H_LOW   = 3'h3,
		H_HIGH  = 3'h2,
		H_TRAIL = 3'h7,
		H_HOLD  = 3'h5
	} ddsc_hst_e;

	typedef struct packed {
		ddsc_hst_e               st;
		logic [7:0]              div;
		logic [15:0]             bitLeft;
		logic [FRAME_BITS-1:0]   txBuf;
		logic [FRAME_BITS-1:0]   rxBuf;
		logic                    sclk;
		logic                    syncN;
		logic                    serial_data_in;
		logic                    ldacN;
		logic                    clrN;
		logic                    s1;
		logic                    s2;
		logic                    s3;
		logic                    sdoF;
		logic [31:0]             rdata;
	} ddsc_host_s;

	ddsc_host_s q;
	ddsc_host_s next_q;

	always_comb begin
		logic tick;
		logic busy;
		next_q = q;
		next_q.s1 = link.sdoLine;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		if (q.s2 == q.s3) begin
			next_q.sdoF = q.s3;
		end
		busy = (q.st != H_IDLE);
		tick = busy && (q.div == 8'h00);
		if (busy) begin
			next_q.div = tick ? HALF_LAST : q.div - 8'h01;
		end

		next_q.rdata = '0;
		if (rd) begin
			unique case (addr)
				H_STATUS: next_q.rdata = {31'h00000000, busy};
				H_RX: next_q.rdata = {8'h00, q.rxBuf[WORD_BITS-1:0]};
				H_CTRL: next_q.rdata = {29'h00000000, ~q.clrN, ~q.ldacN, 1'b0};
				default: next_q.rdata = '0;
			endcase
		end
		if (wr && addr == H_CTRL) begin
			next_q.ldacN = ~wdata[HC_LOAD_OUTPUTS_N];
			next_q.clrN = ~wdata[HC_CLR];
		end
		// each write pushes one word; chained words go farthest first
		if (wr && addr == H_TX && !busy) begin
			next_q.txBuf = FRAME_BITS'({q.txBuf, wdata[WORD_BITS-1:0]});
		end

		unique case (q.st)
			H_IDLE: begin
				if (wr && addr == H_CTRL && wdata[HC_GO]) begin
					next_q.st = H_LEAD;
					next_q.syncN = 1'b0;
					next_q.sclk = 1'b1;
					next_q.serial_data_in = q.txBuf[FRAME_BITS-1];
					next_q.bitLeft = FRAME_LEN;
					next_q.div = HALF_LAST;
				end
			end
			H_LEAD, H_HIGH: begin
				if (tick) begin
					next_q.sclk = 1'b0;
					next_q.st = H_LOW;
				end
			end
			H_LOW: begin
				// sample well after the device moved its readout bit
				if (q.div == SAMPLE_AT) begin
					next_q.rxBuf = {q.rxBuf[FRAME_BITS-2:0], q.sdoF};
				end
				if (tick) begin
					next_q.sclk = 1'b1;
					next_q.txBuf = {q.txBuf[FRAME_BITS-2:0], 1'b0};
					next_q.serial_data_in = q.txBuf[FRAME_BITS-2];
					next_q.bitLeft = q.bitLeft - 16'h0001;
					next_q.st = (q.bitLeft == 16'h0001) ? H_TRAIL : H_HIGH;
				end
			end
			H_TRAIL: begin
				if (tick) begin
					next_q.syncN = 1'b1;
					next_q.st = H_HOLD;
				end
			end
			H_HOLD: begin
				if (tick) begin
					next_q.st = H_IDLE;
				end
			end
			default: next_q.st = H_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.st <= H_IDLE;
			q.sclk <= 1'b1;
			q.syncN <= 1'b1;
			q.ldacN <= 1'b1;
			q.clrN <= 1'b1;
			q.s1 <= 1'b1;
			q.s2 <= 1'b1;
			q.s3 <= 1'b1;
			q.sdoF <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign link.sclk = q.sclk;
	assign link.syncN = q.syncN;
	assign link.serial_data_in = q.serial_data_in;
	assign link.ldacN = q.ldacN;
	assign link.clrN = q.clrN;
	assign rdata = q.rdata;
endmodule

// ===== ddsc_assertions.sv
// concurrent checks on the serial link between host and dac control
`timescale 1ns/10ps
module ddsc_assertions
	import ddsc_pkg::*;
#(
	parameter int CHAIN_N = 1
)
(
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic sclk,
	input  wire logic syncN,
	input  wire logic serial_data_in,
	input  wire logic ldacN,
	input  wire logic clrN,
	input  wire logic sdoOut,
	input  wire logic sdoOe,
	input  wire logic sdoLine
);
	logic [7:0] edgeCnt;
	logic       sclkQ;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// falling serial clock edges seen in the current frame
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			edgeCnt <= 8'h00;
			sclkQ   <= 1'b1;
		end else begin
			sclkQ <= sclk;
			if (syncN)
				edgeCnt <= 8'h00;
			else if (sclkQ && !sclk)
				edgeCnt <= edgeCnt + 8'h01;
		end
	end

	idle_clock_high_a: assert property (syncN |-> sclk)
		else $error("serial clock low outside a frame");
	low_phase_a: assert property ($fell(sclk) |-> !sclk [*8] ##1 sclk)
		else $error("serial clock low phase has wrong length");
	frame_start_a: assert property ($fell(syncN) |-> sclk && $past(sclk))
		else $error("frame opened with serial clock low");
	frame_end_a: assert property ($rose(syncN) |-> sclk && $past(sclk, 8))
		else $error("frame closed too soon after last clock");
	sync_gap_a: assert property ($rose(syncN) |-> syncN [*8])
		else $error("frame select high too briefly");
	edge_count_a: assert property ($rose(syncN) |->
		edgeCnt == 8'(WORD_BITS * CHAIN_N))
		else $error("frame closed with wrong falling edge count");
	serial_data_in_hold_a: assert property (!sclk |-> $stable(serial_data_in))
		else $error("serial data moved while clock low");
	sdo_hold_a: assert property (!sclk |-> $stable(sdoOut))
		else $error("readout bit moved while clock low");
	oe_release_a: assert property ($fell(sdoOe) |-> syncN)
		else $error("readout released inside a frame");
	load_after_frame_a: assert property ($fell(ldacN) |-> syncN)
		else $error("load strobe fell inside a frame");
endmodule

// ===== test_dual_dac_serial_control.sv
// self-checking bench: host with a device, plus a raw-driven device
`timescale 1ns/10ps
module test_dual_dac_serial_control
	import ddsc_pkg::*;
;
	logic        sys_clk;
	logic        nrst;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        codingSel;
	logic        codingSel2;
	logic [15:0] dacCodeA;
	logic [15:0] dacCodeB;
	logic [1:0]  channelOn;
	logic [15:0] dacCodeA2;
	logic [31:0] ctlBits;
	logic [31:0] v;
	logic [15:0] d;
	logic [15:0] expA;
	logic [15:0] expB;
	int          nMismatch;
	int          numChecks;

	ddsc_link_if link ();
	ddsc_link_if link2 ();

	ddsc_host #(.CHAIN_N(1)) ddsc_host_i (.sys_clk(sys_clk), .nrst(nrst),
		.link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));
	ddsc_device ddsc_device_i (.sys_clk(sys_clk), .nrst(nrst), .link(link),
		.codingSel(codingSel), .dacCodeA(dacCodeA), .dacCodeB(dacCodeB),
		.channelOn(channelOn));
	// second device takes hand-driven frames, some deliberately malformed, from the bench
	ddsc_device ddsc_device_i2 (.sys_clk(sys_clk), .nrst(nrst),
		.link(link2), .codingSel(codingSel2), .dacCodeA(dacCodeA2),
		.dacCodeB(), .channelOn());
	ddsc_assertions #(.CHAIN_N(1)) ddsc_assertions_i (.sys_clk(sys_clk),
		.nrst(nrst), .sclk(link.sclk), .syncN(link.syncN),
		.serial_data_in(link.serial_data_in), .ldacN(link.ldacN), .clrN(link.clrN),
		.sdoOut(link.sdoOut), .sdoOe(link.sdoOe), .sdoLine(link.sdoLine));

	always #5 sys_clk = ~sys_clk;

	function automatic logic [23:0] mk(input logic [2:0] r,
		input logic [2:0] a, input logic [15:0] x);
		return {2'b00, r, a, x};
	endfunction

	function automatic logic [15:0] offsetCode(input logic [15:0] x,
		input logic twos);
		return twos ? x ^ 16'h8000 : x;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrReg(input logic [7:0] a, input logic [31:0] x);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rdReg(input logic [7:0] a, output logic [31:0] x);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		x = rdata;
		@(posedge sys_clk);
	endtask

	task automatic setCtl(input logic [31:0] x);
		ctlBits = x;
		wrReg(H_CTRL, x);
		// pins pass a synchroniser before the device acts
		repeat (10) @(posedge sys_clk);
	endtask

	task automatic sendWord(input logic [23:0] w);
		logic [31:0] s;
		wrReg(H_TX, {8'h00, w});
		wrReg(H_CTRL, ctlBits | 32'h1);
		s = 32'h1;
		for (int i = 0; i < 400 && s[0] !== 1'b0; i++)
			rdReg(H_STATUS, s);
		chk(s, 32'h0);
	endtask

	// hand-made frame with an arbitrary count of falling edges
	task automatic raw(input logic [23:0] w, input int n);
		link2.syncN <= 1'b0;
		for (int i = 0; i < n; i++) begin
			link2.serial_data_in <= w[23 - (i % 24)];
			repeat (8) @(posedge sys_clk);
			link2.sclk <= 1'b0;
			repeat (8) @(posedge sys_clk);
			link2.sclk <= 1'b1;
		end
		repeat (8) @(posedge sys_clk);
		link2.syncN <= 1'b1;
		repeat (16) @(posedge sys_clk);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		{addr, wdata, wr, rd, ctlBits, codingSel2} = '0;
		{nMismatch, numChecks} = '0;
		{expA, expB} = '0;
		{link2.sclk, link2.syncN, link2.serial_data_in} = 3'b110;
		link2.ldacN = 1'b0;
		link2.clrN = 1'b1;
		void'($urandom(32'h3C75));
		codingSel = 1'($urandom);
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		chk({dacCodeA, dacCodeB}, 32'h0);
		chk({30'h0, channelOn}, 32'h0);
		setCtl(32'h2);
		sendWord(mk(REG_DAC, ADDR_A, 16'hA5A5));
		chk({16'h0, dacCodeA}, 32'h0);
		sendWord(mk(REG_RANGE, ADDR_ALL, 16'h0000));
		sendWord(mk(REG_POWER, ADDR_A, 16'h0005));
		chk({30'h0, channelOn}, 32'h3);
		for (int k = 0; k < 6; k++) begin
			d = (k == 0) ? 16'hFFFF : 16'($urandom);
			sendWord(mk(REG_DAC, k[0] ? ADDR_B : ADDR_A, d));
			if (k[0])
				expB = d;
			else
				expA = d;
			chk({dacCodeA, dacCodeB}, {expA, expB});
		end
		setCtl(32'h0);
		sendWord(mk(REG_DAC, ADDR_A, ~expA));
		sendWord(mk(REG_DAC, ADDR_B, ~expB));
		chk({dacCodeA, dacCodeB}, {expA, expB});
		setCtl(32'h2);
		chk({dacCodeA, dacCodeB}, ~{expA, expB});
		sendWord(mk(REG_CTRL, CMD_SETUP, 16'h0004));
		setCtl(32'h6);
		chk({dacCodeA, dacCodeB}, {CODE_MID, CODE_MID});
		sendWord(mk(REG_DAC, ADDR_A, 16'h1357));
		chk({dacCodeA, dacCodeB}, {CODE_MID, CODE_MID});
		setCtl(32'h2);
		chk({dacCodeA, dacCodeB}, {CODE_MID, CODE_MID});
		sendWord(mk(REG_CTRL, CMD_SETUP, 16'h0000));
		sendWord(mk(REG_CTRL, CMD_CLEAR, 16'h0000));
		chk({dacCodeA, dacCodeB}, {CODE_ZERO, CODE_ZERO});
		// the previous word leaves on the readout pin during this frame
		rdReg(H_RX, v);
		chk(v, {8'h00, mk(REG_CTRL, CMD_SETUP, 16'h0000)});
		sendWord(mk(REG_CTRL, CMD_SETUP, 16'h0001));
		d = 16'($urandom);
		sendWord(mk(REG_DAC, ADDR_A, d));
		chk({16'h0, dacCodeA}, {16'h0, d});
		sendWord(24'h800000);
		sendWord(24'h180000);
		rdReg(H_RX, v);
		chk(v & 32'hFFFFFF, {16'h0, d});
		sendWord(24'h180000);
		rdReg(H_RX, v);
		chk(v & 32'hFFFFFF, 32'hFFFFFF);
		raw(mk(REG_RANGE, ADDR_A, {13'h0, RANGE_BIP_LOW}), 24);
		raw(mk(REG_POWER, ADDR_A, 16'h0001), 24);
		raw(mk(REG_DAC, ADDR_A, 16'h1234), 23);
		raw(mk(REG_DAC, ADDR_A, 16'h1234), 25);
		chk({16'h0, dacCodeA2}, 32'h0);
		for (int k = 0; k < 3; k++) begin
			d = (k == 0) ? 16'h0000 : 16'($urandom);
			codingSel2 <= k[0];
			raw(mk(REG_DAC, ADDR_A, d), 24);
			chk({16'h0, dacCodeA2}, {16'h0, offsetCode(d, k[0])});
		end
		// two whole words per frame still latch, as in a chain
		raw(mk(REG_DAC, ADDR_A, 16'h2468), 48);
		chk({16'h0, dacCodeA2}, 32'h2468);
		summarize();
	end

	// roughly eight times the expected run length
	initial begin
		#1000000;
		nMismatch++;
		summarize();
	end
endmodule
